// *** core/cmbf_map.vh ***
// Purpose: constants for the core memory bus fabric
// Assumes: one core clock, all buses synchronous to it
// Notes:   address widths and data widths are fixed
`ifndef CMBF_MAP_VH
`define CMBF_MAP_VH
`define CMBF_PA_W        21
`define CMBF_XA_W        24
`define CMBF_XA_MSB      23
`define CMBF_PD_W        16
`define CMBF_CD_W        32
`define CMBF_PR_W        16
// Size codes on the primary data bus
`define CMBF_SZ_BYTE     2'h0
`define CMBF_SZ_WORD     2'h1
`define CMBF_SZ_LONG     2'h2
// Memory-mapped peripheral window on the primary address bus
`define CMBF_IO_BASE     24'hfff000
`define CMBF_IO_MASK     24'hfff000
// Peripheral register index width inside the window
`define CMBF_IO_IDX_W    12
`endif

// *** core/cmbf_sel_reg.v ***
// Purpose: registered source select for the primary read return
// Assumes: sel and data valid in the same cycle
// Notes:   output comes from a flop so read data meet the top's style
`include "cmbf_map.vh"
module cmbf_sel_reg (
  // Clock and reset
  input  wire                     mclk,
  input  wire                     nrst,
  input  wire                     ce,
  // Sources
  input  wire                     load,
  input  wire                     io_sel,
  input  wire [`CMBF_CD_W-1:0]    mem_data,
  input  wire [`CMBF_PR_W-1:0]    io_data,
  // Result
  output reg  [`CMBF_CD_W-1:0]    rd_q
);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rd_q <= 32'h0000_0000;
    end else if (ce && load) begin
      if (io_sel) begin
        rd_q <= {16'h0000, io_data};
      end else begin
        rd_q <= mem_data;
      end
    end
  end
endmodule

// *** core/cmbf_fabric.v ***
// Purpose: route core bus requests to program memory, data memory and
//          the peripheral register bus, returning read data to the core
// Assumes: memories and peripherals answer in the cycle after request
// Notes:   one cycle of registration on every path, no wait states
`include "cmbf_map.vh"
// Overview of operation
// - Program memory is addressed by the 21-bit program address and returns 16-bit read data.
// - Program memory writes carry only the low 16 bits of the core write data.
// - Primary data reads return up to 32 bits addressed by the 24-bit primary address.
// - Primary data writes store up to 32 bits of core write data at the primary address.
// - The primary address supports byte, word and long sizes and decodes a peripheral window.
// - Byte accesses have the top address bit forced to zero.
// - The secondary word-only read uses its own 24-bit address and 16-bit return bus.
// - The peripheral register bus is 16 bits and runs at the data memory rate with no waits.
// - Peripheral writes take core write data and peripheral reads return on the primary read bus.
// - Active-high strobes assert high and active-low strobes assert low.
module cmbf_fabric (
  // Clock and reset
  input  wire                      mclk,
  input  wire                      nrst,
  input  wire                      ce,
  // Core program side
  input  wire [`CMBF_PA_W-1:0]     core_pab,
  input  wire                      core_prd,
  input  wire                      core_pwr,
  output reg  [`CMBF_PD_W-1:0]     core_pdb_q,
  // Core primary data side
  input  wire [`CMBF_XA_W-1:0]     primary_data_address_bus,
  input  wire [1:0]                core_xsize,
  input  wire                      core_xrd,
  input  wire                      core_xwr,
  input  wire [`CMBF_CD_W-1:0]     core_cdbw,
  output wire [`CMBF_CD_W-1:0]     core_cdbr_q,
  // Core secondary side
  input  wire [`CMBF_XA_W-1:0]     secondary_data_address_bus,
  input  wire                      core_x2rd,
  output reg  [`CMBF_PD_W-1:0]     secondary_read_bus,
  // Program memory
  output reg  [`CMBF_PA_W-1:0]     pm_addr_q,
  output reg                       pm_rd_q,
  output reg                       pm_wr_q,
  output reg  [`CMBF_PD_W-1:0]     pm_wdata_q,
  input  wire [`CMBF_PD_W-1:0]     pm_rdata,
  // Data memory, primary port
  output reg  [`CMBF_XA_W-1:0]     dm_addr_q,
  output reg  [1:0]                dm_size_q,
  output reg                       dm_rd_q,
  output reg                       dm_wr_q,
  output reg  [`CMBF_CD_W-1:0]     dm_wdata_q,
  input  wire [`CMBF_CD_W-1:0]     dm_rdata,
  // Data memory, secondary port
  output reg  [`CMBF_XA_W-1:0]     dm2_addr_q,
  output reg                       dm2_rd_q,
  input  wire [`CMBF_PD_W-1:0]     dm2_rdata,
  // Peripheral register bus
  output reg  [`CMBF_IO_IDX_W-1:0] peripheral_register_bus_addr_q,
  output reg                       peripheral_register_bus_rd_q,
  output reg                       peripheral_register_bus_wr_n_q,
  output reg  [`CMBF_PR_W-1:0]     peripheral_register_bus_wdata_q,
  input  wire [`CMBF_PR_W-1:0]     peripheral_register_bus_rdata
);
  // Effective primary address and window decode
  reg  [`CMBF_XA_W-1:0]     xa_eff;
  reg                       io_hit;
  // Program path
  reg  [`CMBF_PA_W-1:0]     pm_addr_d;
  reg                       pm_rd_d;
  reg                       pm_wr_d;
  reg  [`CMBF_PD_W-1:0]     pm_wdata_d;
  reg                       p_pend_d;
  reg                       p_pend_q;
  reg  [`CMBF_PD_W-1:0]     core_pdb_d;
  // Primary data path
  reg  [`CMBF_XA_W-1:0]     dm_addr_d;
  reg  [1:0]                dm_size_d;
  reg                       dm_rd_d;
  reg                       dm_wr_d;
  reg  [`CMBF_CD_W-1:0]     dm_wdata_d;
  reg                       rd_pend_d;
  reg                       rd_pend_q;
  reg                       io_pend_d;
  reg                       io_pend_q;
  // Peripheral register bus
  reg  [`CMBF_IO_IDX_W-1:0] peripheral_register_bus_addr_d;
  reg                       peripheral_register_bus_rd_d;
  reg                       peripheral_register_bus_wr_n_d;
  reg  [`CMBF_PR_W-1:0]     peripheral_register_bus_wdata_d;
  // Secondary word-only read
  reg  [`CMBF_XA_W-1:0]     dm2_addr_d;
  reg                       dm2_rd_d;
  reg                       x2_pend_d;
  reg                       x2_pend_q;
  reg  [`CMBF_PD_W-1:0]     secondary_read_d;

  // Byte accesses live in the lower half only, so a byte access can never
  // land in the peripheral window at the top of the map
  always @* begin
    xa_eff = primary_data_address_bus;
    if (core_xsize == `CMBF_SZ_BYTE) begin
      xa_eff[`CMBF_XA_MSB] = 1'b0;
    end
    io_hit = ((xa_eff & `CMBF_IO_MASK) == `CMBF_IO_BASE);
  end

  // Program path: request out on the next edge, data back one edge later
  always @* begin
    pm_addr_d  = core_pab;
    pm_rd_d    = core_prd;
    pm_wr_d    = core_pwr;
    pm_wdata_d = core_cdbw[`CMBF_PD_W-1:0];
    p_pend_d   = core_prd;
    core_pdb_d = core_pdb_q;
    if (p_pend_q) begin
      core_pdb_d = pm_rdata;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      pm_addr_q  <= 21'h0_0000;
      pm_rd_q    <= 1'b0;
      pm_wr_q    <= 1'b0;
      pm_wdata_q <= 16'h0000;
      p_pend_q   <= 1'b0;
      core_pdb_q <= 16'h0000;
    end else if (ce) begin
      pm_addr_q  <= pm_addr_d;
      pm_rd_q    <= pm_rd_d;
      pm_wr_q    <= pm_wr_d;
      pm_wdata_q <= pm_wdata_d;
      p_pend_q   <= p_pend_d;
      core_pdb_q <= core_pdb_d;
    end
  end

  // Primary data path; memory strobes stay off inside the I/O window so a
  // peripheral access never disturbs the memory behind the same address
  always @* begin
    dm_addr_d  = xa_eff;
    dm_size_d  = core_xsize;
    dm_rd_d    = core_xrd & ~io_hit;
    dm_wr_d    = core_xwr & ~io_hit;
    dm_wdata_d = core_cdbw;
    rd_pend_d  = core_xrd;
    io_pend_d  = io_hit;
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dm_addr_q  <= 24'h00_0000;
      dm_size_q  <= `CMBF_SZ_WORD;
      dm_rd_q    <= 1'b0;
      dm_wr_q    <= 1'b0;
      dm_wdata_q <= 32'h0000_0000;
      rd_pend_q  <= 1'b0;
      io_pend_q  <= 1'b0;
    end else if (ce) begin
      dm_addr_q  <= dm_addr_d;
      dm_size_q  <= dm_size_d;
      dm_rd_q    <= dm_rd_d;
      dm_wr_q    <= dm_wr_d;
      dm_wdata_q <= dm_wdata_d;
      rd_pend_q  <= rd_pend_d;
      io_pend_q  <= io_pend_d;
    end
  end

  // Peripheral path keeps the data memory cadence, so it adds no wait state;
  // its write strobe is low true and idles high
  always @* begin
    peripheral_register_bus_addr_d  = xa_eff[`CMBF_IO_IDX_W-1:0];
    peripheral_register_bus_rd_d    = core_xrd & io_hit;
    peripheral_register_bus_wr_n_d  = ~(core_xwr & io_hit);
    peripheral_register_bus_wdata_d = core_cdbw[`CMBF_PR_W-1:0];
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      peripheral_register_bus_addr_q  <= 12'h000;
      peripheral_register_bus_rd_q    <= 1'b0;
      peripheral_register_bus_wr_n_q  <= 1'b1;
      peripheral_register_bus_wdata_q <= 16'h0000;
    end else if (ce) begin
      peripheral_register_bus_addr_q  <= peripheral_register_bus_addr_d;
      peripheral_register_bus_rd_q    <= peripheral_register_bus_rd_d;
      peripheral_register_bus_wr_n_q  <= peripheral_register_bus_wr_n_d;
      peripheral_register_bus_wdata_q <= peripheral_register_bus_wdata_d;
    end
  end

  // Secondary word-only read, same timing as the program path
  always @* begin
    dm2_addr_d       = secondary_data_address_bus;
    dm2_rd_d         = core_x2rd;
    x2_pend_d        = core_x2rd;
    secondary_read_d = secondary_read_bus;
    if (x2_pend_q) begin
      secondary_read_d = dm2_rdata;
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dm2_addr_q         <= 24'h00_0000;
      dm2_rd_q           <= 1'b0;
      x2_pend_q          <= 1'b0;
      secondary_read_bus <= 16'h0000;
    end else if (ce) begin
      dm2_addr_q         <= dm2_addr_d;
      dm2_rd_q           <= dm2_rd_d;
      x2_pend_q          <= x2_pend_d;
      secondary_read_bus <= secondary_read_d;
    end
  end

  // Read return mux kept in its own registered stage
  cmbf_sel_reg u_rsel (
    .mclk     (mclk),
    .nrst     (nrst),
    .ce       (ce),
    .load     (rd_pend_q),
    .io_sel   (io_pend_q),
    .mem_data (dm_rdata),
    .io_data  (peripheral_register_bus_rdata),
    .rd_q     (core_cdbr_q)
  );
endmodule

// *** tb/cmbf_mem_model.sv ***
// Purpose: memories and peripherals behind the fabric
// Assumes: reads answer in the same cycle as the strobe
// Notes:   idle buses show a running count, never stale data
module cmbf_mem_model (
  // Requests
  input  wire        mclk, pm_rd_q, dm_rd_q, dm2_rd_q,
  input  wire        peripheral_register_bus_rd_q,
  input  wire [20:0] pm_addr_q,
  input  wire [23:0] dm_addr_q, dm2_addr_q,
  input  wire [11:0] peripheral_register_bus_addr_q,
  // Answers
  output wire [15:0] pm_rdata, dm2_rdata, peripheral_register_bus_rdata,
  output wire [31:0] dm_rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] cnt_q = 16'h0;
  always @(posedge mclk) cnt_q <= cnt_q + 16'h1;
  assign pm_rdata = pm_rd_q ? pm_addr_q[15:0] ^ 16'ha5a5 : cnt_q;
  assign dm_rdata = dm_rd_q ? {dm_addr_q[15:0], ~dm_addr_q[15:0]}
                            : {2{cnt_q}};
  assign dm2_rdata = dm2_rd_q ? ~dm2_addr_q[15:0] : cnt_q;
  assign peripheral_register_bus_rdata = peripheral_register_bus_rd_q ?
    {4'h0, peripheral_register_bus_addr_q} ^ 16'h0f0f : cnt_q;
endmodule

// *** tb/cmbf_chk.sv ***
// Purpose: port checks for the bus fabric
// Assumes: ce held high, so every strobe is taken
// Notes:   window decode mirrors the chosen peripheral base
`include "cmbf_map.vh"
module cmbf_chk (
  input wire        mclk, nrst, core_prd, core_pwr, core_xrd, core_xwr,
  input wire        core_x2rd, pm_rd_q, pm_wr_q, dm_rd_q, dm_wr_q, dm2_rd_q,
  input wire        peripheral_register_bus_wr_n_q,
  input wire [1:0]  core_xsize,
  input wire [15:0] pm_rdata, pm_wdata_q, core_pdb_q, secondary_read_bus,
  input wire [15:0] dm2_rdata, peripheral_register_bus_wdata_q,
  input wire [15:0] peripheral_register_bus_rdata,
  input wire [20:0] core_pab, pm_addr_q,
  input wire [23:0] primary_data_address_bus, dm_addr_q,
  input wire [23:0] secondary_data_address_bus, dm2_addr_q,
  input wire [31:0] core_cdbw, dm_wdata_q, dm_rdata, core_cdbr_q
);
  wire io = core_xsize != `CMBF_SZ_BYTE &&
    (primary_data_address_bus & `CMBF_IO_MASK) == `CMBF_IO_BASE;
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  pm_rd_a: assert property (core_prd |=> pm_rd_q &&
    pm_addr_q == $past(core_pab) ##1 core_pdb_q == $past(pm_rdata))
    else $error("program read wrong");
  pm_wr_a: assert property (core_pwr |=> pm_wr_q &&
    pm_wdata_q == $past(core_cdbw[15:0])) else $error("program write wrong");
  dm_rd_a: assert property (core_xrd && !io |=> dm_rd_q ##1
    core_cdbr_q == $past(dm_rdata)) else $error("data read wrong");
  dm_wr_a: assert property (core_xwr && !io |=> dm_wr_q &&
    dm_wdata_q == $past(core_cdbw)) else $error("data write wrong");
  byte_msb_a: assert property ((core_xrd || core_xwr) &&
    core_xsize == `CMBF_SZ_BYTE |=> !dm_addr_q[23]) else $error("byte msb");
  sec_rd_a: assert property (core_x2rd |=> dm2_rd_q &&
    dm2_addr_q == $past(secondary_data_address_bus) ##1
    secondary_read_bus == $past(dm2_rdata)) else $error("second read wrong");
  io_wr_a: assert property (core_xwr && io |=> !dm_wr_q &&
    !peripheral_register_bus_wr_n_q && peripheral_register_bus_wdata_q ==
    $past(core_cdbw[15:0])) else $error("peripheral write wrong");
  io_rd_a: assert property (core_xrd && io |=> !dm_rd_q ##1
    core_cdbr_q == {16'h0, $past(peripheral_register_bus_rdata)})
    else $error("peripheral read wrong");
  cover property (core_xrd && io);
  cover property (core_xrd && core_x2rd);
  cover property (core_xwr && core_xsize == `CMBF_SZ_BYTE);
endmodule

// *** tb/cmbf_fabric_tb_top.sv ***
// Purpose: directed tests of the core memory bus fabric
// Assumes: model answers in the same cycle as each strobe
// Notes:   ce stays high; freezing is left untested
`include "cmbf_map.vh"
module cmbf_fabric_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk = 0, nrst = 0, ce = 1, core_prd = 0, core_pwr = 0;
  logic core_xrd = 0, core_xwr = 0, core_x2rd = 0;
  logic [1:0] core_xsize = 2'h0;
  logic [20:0] core_pab = 21'h0;
  logic [23:0] primary_data_address_bus = 0, secondary_data_address_bus = 0;
  logic [31:0] core_cdbw = 32'h0;
  wire pm_rd_q, pm_wr_q, dm_rd_q, dm_wr_q, dm2_rd_q;
  wire peripheral_register_bus_rd_q, peripheral_register_bus_wr_n_q;
  wire [1:0] dm_size_q;
  wire [11:0] peripheral_register_bus_addr_q;
  wire [15:0] core_pdb_q, secondary_read_bus, pm_wdata_q, pm_rdata, dm2_rdata;
  wire [15:0] peripheral_register_bus_wdata_q, peripheral_register_bus_rdata;
  wire [20:0] pm_addr_q;
  wire [23:0] dm_addr_q, dm2_addr_q;
  wire [31:0] core_cdbr_q, dm_wdata_q, dm_rdata;
  int failures = 0, tests_run = 0;
  cmbf_fabric dut_u (.*);
  cmbf_mem_model mem_u (.*);
  task automatic chk(input logic [47:0] s, e);
    tests_run++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Strobes last one cycle; memory side is judged just after the taken edge
  task automatic go;
    @(posedge mclk);
    {core_prd, core_pwr, core_xrd, core_xwr, core_x2rd} <= 5'h0;
    #1;
  endtask
  task automatic t_prog;
    @(posedge mclk) core_prd <= 1;
    core_pab <= 21'h1abcd;
    go;
    chk({pm_rd_q, pm_addr_q}, {1'h1, 21'h1abcd});
    @(posedge mclk) #1 chk(core_pdb_q, 16'h0e68);
    @(posedge mclk) core_pwr <= 1;
    core_cdbw <= 32'hdead1234;
    go;
    chk({pm_wr_q, pm_wdata_q}, 17'h11234);
    $display("program test done");
  endtask
  task automatic t_data;
    for (logic [1:0] s = 0; s < 3; s++) begin
      @(posedge mclk) core_xwr <= 1;
      core_xsize <= s;
      primary_data_address_bus <= 24'h800010;
      core_cdbw <= 32'h12345678;
      go;
      chk({dm_wr_q, dm_size_q, dm_wdata_q},
          {1'h1, s, 32'h12345678});
      chk(dm_addr_q, s == `CMBF_SZ_BYTE ? 24'h10 : 24'h800010);
      @(posedge mclk) core_xrd <= 1;
      go;
      chk(dm_rd_q, 1);
      @(posedge mclk) #1 chk(core_cdbr_q, 32'h0010ffef);
    end
    $display("data test done");
  endtask
  task automatic t_dual;
    @(posedge mclk) core_xrd <= 1;
    core_x2rd <= 1;
    core_xsize <= `CMBF_SZ_WORD;
    primary_data_address_bus <= 24'h200;
    secondary_data_address_bus <= 24'h400300;
    go;
    chk({dm2_rd_q, dm2_addr_q}, {1'h1, 24'h400300});
    @(posedge mclk) #1 chk(secondary_read_bus, 16'hfcff);
    chk(core_cdbr_q, 32'h0200fdff);
    $display("dual read test done");
  endtask
  task automatic t_io;
    @(posedge mclk) core_xwr <= 1;
    primary_data_address_bus <= 24'hfff123;
    core_cdbw <= 32'hbeef5a5a;
    go;
    chk({dm_wr_q, peripheral_register_bus_wr_n_q}, 0);
    chk(peripheral_register_bus_addr_q, 12'h123);
    chk(peripheral_register_bus_wdata_q, 16'h5a5a);
    @(posedge mclk) core_xrd <= 1;
    go;
    chk({dm_rd_q, peripheral_register_bus_rd_q}, 1);
    chk(peripheral_register_bus_wr_n_q, 1);
    @(posedge mclk) #1 chk(core_cdbr_q, 32'he2c);
    $display("peripheral test done");
  endtask
  task automatic stop_test;
    $display("compares %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    forever #12.5 mclk = ~mclk;
  end
  initial begin
    repeat (3) @(posedge mclk);
    nrst <= 1;
    t_prog;
    t_data;
    t_dual;
    t_io;
    stop_test;
  end
  // Whole run is under 60 cycles; this limit only catches a hang
  initial begin
    #20us;
    failures++;
    stop_test;
  end
endmodule
bind cmbf_fabric cmbf_chk chk_u (.*);
